// ===== inc/sbs_cfg.svh
// Constants for the synchronous burst SRAM access block
`ifndef SBS_CFG_SVH
`define SBS_CFG_SVH
`define SBS_ADDR_W   15
`define SBS_DATA_W   9
`define SBS_DEPTH    32768
`define SBS_BURST_W  2
`define SBS_BURST_Z  2'h0
`define SBS_BURST_B0 2'h1
`define SBS_BURST_B1 2'h2
`define SBS_BURST_B2 2'h3
`define SBS_DATA_Z   9'h000
`define SBS_ADDR_Z   15'h0000
`endif

// ===== inc/sbs_pkg.sv
// Types shared by the burst SRAM access block
`include "sbs_cfg.svh"
package sbs_pkg;
   // Kind of cycle decoded from the registered controls
   typedef enum logic [2:0] {
      SBS_IDLE,
      SBS_BEGIN_RD,
      SBS_BEGIN_WR,
      SBS_CONT,
      SBS_DESEL
   } sbs_op_e;
   typedef logic [`SBS_ADDR_W-1:0] sbs_addr_t;
   typedef logic [`SBS_DATA_W-1:0] sbs_data_t;
endpackage

// ===== rtl/sbs_burst_ctr.sv
// Two-bit burst counter and wrap-order address generator
`timescale 1ns/1ns
`include "sbs_cfg.svh"
module sbs_burst_ctr
   import sbs_pkg::*;
(
   input  wire logic                    clock,
   input  wire logic                    rst,
   input  wire logic                    load,
   input  wire logic                    step,
   input  wire logic [`SBS_BURST_W-1:0] base_low,
   output logic      [`SBS_BURST_W-1:0] low_bits
);
   logic [`SBS_BURST_W-1:0] count_r;

   // Count resets on a new base, steps on advance
   always_ff @(posedge clock)
   begin
      if (rst || load)
         count_r <= `SBS_BURST_Z;
      else if (step)
         count_r <= count_r + `SBS_BURST_B0;
   end

   // Counter value XORed onto base gives the wrap order; 3 then wraps to 0
   assign low_bits = base_low ^ count_r;

   burst_order_a: assert property (@(posedge clock) disable iff (rst)
      (!load && step) |=> (count_r == $past(count_r) + `SBS_BURST_B0))
      else $error("burst counter failed to step");
endmodule

// ===== rtl/sbs_array.sv
// Storage array, one write port and one read port sharing a single address
`timescale 1ns/1ns
`include "sbs_cfg.svh"
module sbs_array
   import sbs_pkg::*;
(
   input  wire logic      clock,
   input  wire logic      wr_en,
   input  wire sbs_addr_t addr,
   input  wire sbs_data_t wr_data,
   output sbs_data_t      rd_data
);
   sbs_data_t mem [0:`SBS_DEPTH-1];

   // Self-timed write: stored on the edge after capture, no pulse needed
   always_ff @(posedge clock)
   begin
      if (wr_en)
         mem[addr] <= wr_data;
   end

   // Asynchronous read of the current access address
   assign rd_data = mem[addr];
endmodule

// ===== rtl/sbs_top.sv
// Synchronous burst SRAM access logic: input registers, burst control, data pins
`timescale 1ns/1ns
`include "sbs_cfg.svh"
module sbs_top
   import sbs_pkg::*;
(
   input  wire logic      clock,
   input  wire logic      rst,
   input  wire sbs_addr_t addr_in,
   input  wire logic      proc_addr_strobe_n,
   input  wire logic      ctrl_addr_strobe_n,
   input  wire logic      burst_advance_n,
   input  wire logic      write_en_n,
   input  wire logic      out_en_n,
   input  wire logic      chip_sel_high,
   input  wire logic      chip_sel_low_n,
   input  wire sbs_data_t data_in,
   output sbs_data_t      data_out,
   output logic           data_oe
);
   // Registered copies of all synchronous inputs
   sbs_addr_t addr_r;
   sbs_data_t din_r;
   logic      ps_n_r;
   logic      cs_n_r;
   logic      adv_n_r;
   logic      we_n_r;
   logic      sel_r;
   logic      sampled_r;
   // Burst and access state
   sbs_addr_t base_r;
   logic      active_r;
   logic      rd_r;
   sbs_data_t dout_r;
   sbs_op_e   op;
   logic      load;
   logic      step;
   logic      do_wr;
   logic      do_rd;
   logic      new_active;
   logic [`SBS_BURST_W-1:0] low_bits;
   sbs_addr_t acc_addr;
   sbs_data_t rd_data;

   // Chip select is a pure AND of its two polarities
   function automatic logic sel_true(input logic hi, input logic lo_n);
      sel_true = hi && !lo_n;
   endfunction

   // Input register stage: every control except output enable is captured here
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         addr_r    <= `SBS_ADDR_Z;
         din_r     <= `SBS_DATA_Z;
         ps_n_r    <= 1'b1;
         cs_n_r    <= 1'b1;
         adv_n_r   <= 1'b1;
         we_n_r    <= 1'b1;
         sel_r     <= 1'b0;
         sampled_r <= 1'b0;
      end
      else
      begin
         addr_r    <= addr_in;
         din_r     <= data_in;
         ps_n_r    <= proc_addr_strobe_n;
         cs_n_r    <= ctrl_addr_strobe_n;
         adv_n_r   <= burst_advance_n;
         we_n_r    <= write_en_n;
         sel_r     <= sel_true(chip_sel_high, chip_sel_low_n);
         sampled_r <= 1'b1;
      end
   end

   // Cycle decode; processor strobe outranks controller strobe and write enable
   always_comb
   begin
      op = SBS_IDLE;
      if (!sampled_r)
         op = SBS_IDLE;
      else if (!ps_n_r || !cs_n_r)
      begin
         // Selects only matter on a base load
         if (!sel_r)
            op = SBS_DESEL;
         else if (!ps_n_r)
            op = SBS_BEGIN_RD;
         else if (!we_n_r)
            op = SBS_BEGIN_WR;
         else
            op = SBS_BEGIN_RD;
      end
      else
         op = SBS_CONT;
   end

   assign load = (op == SBS_BEGIN_RD) || (op == SBS_BEGIN_WR);
   // Counter steps at the end of this cycle; the access address adds one so this cycle uses the new address
   assign step = (op == SBS_CONT) && !adv_n_r && active_r;
   assign new_active = load || (active_r && op != SBS_DESEL);

   // Burst is live from a begin until a deselect
   always_ff @(posedge clock)
   begin
      if (rst)
         active_r <= 1'b0;
      else
         active_r <= new_active;
   end

   // Base address latched on each begin
   always_ff @(posedge clock)
   begin
      if (rst)
         base_r <= `SBS_ADDR_Z;
      else if (load)
         base_r <= addr_r;
   end

   sbs_burst_ctr u_ctr (
      .clock    (clock),
      .rst      (rst),
      .load     (load),
      .step     (step),
      .base_low (base_r[`SBS_BURST_W-1:0]),
      .low_bits (low_bits)
   );

   // Access address: external on begin, burst order during continue/suspend
   always_comb
   begin
      if (load)
         acc_addr = addr_r;
      else if (step)
         // Counter still holds the old count here, so add one to it rather than flip bit 0
         acc_addr = {base_r[`SBS_ADDR_W-1:`SBS_BURST_W], base_r[`SBS_BURST_W-1:0] ^
                     `SBS_BURST_W'((low_bits ^ base_r[`SBS_BURST_W-1:0]) + `SBS_BURST_B0)};
      else
         acc_addr = {base_r[`SBS_ADDR_W-1:`SBS_BURST_W], low_bits};
   end

   // Writes: controller-strobe begin with write low, or continue/suspend with write low in a live burst
   assign do_wr = (op == SBS_BEGIN_WR) ||
                  ((op == SBS_CONT) && active_r && !we_n_r);
   assign do_rd = (op == SBS_BEGIN_RD) ||
                  ((op == SBS_CONT) && active_r && we_n_r);

   sbs_array u_array (
      .clock   (clock),
      .wr_en   (do_wr),
      .addr    (acc_addr),
      .wr_data (din_r),
      .rd_data (rd_data)
   );

   // Read data register and read-phase flag for the output buffer
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         dout_r <= `SBS_DATA_Z;
         rd_r   <= 1'b0;
      end
      else
      begin
         rd_r <= do_rd;
         if (do_rd)
            dout_r <= rd_data;
      end
   end

   assign data_out = dout_r;
   // Output enable is asynchronous; a write or deselect floats the pins
   assign data_oe  = rd_r && !out_en_n;

   // Inline checks
   wr_floats_pins_a: assert property (@(posedge clock) disable iff (rst)
      (do_wr) |=> !data_oe)
      else $error("pins driven after write");
   desel_stops_a: assert property (@(posedge clock) disable iff (rst)
      (op == SBS_DESEL) |=> !active_r)
      else $error("burst live after deselect");
   proc_read_a: assert property (@(posedge clock) disable iff (rst)
      (sampled_r && !ps_n_r && sel_r) |-> (do_rd && !do_wr && acc_addr == addr_r))
      else $error("processor strobe not a read");
   ctrl_write_a: assert property (@(posedge clock) disable iff (rst)
      (sampled_r && ps_n_r && !cs_n_r && sel_r && !we_n_r) |-> (do_wr && acc_addr == addr_r))
      else $error("controller write not begun");
   ctrl_read_a: assert property (@(posedge clock) disable iff (rst)
      (sampled_r && ps_n_r && !cs_n_r && sel_r && we_n_r) |-> (do_rd && !do_wr))
      else $error("controller read not begun");
   suspend_hold_a: assert property (@(posedge clock) disable iff (rst)
      (op == SBS_CONT && active_r && adv_n_r && !$past(load)) |-> $stable(acc_addr))
      else $error("suspend moved address");
   advance_next_a: assert property (@(posedge clock) disable iff (rst)
      (step && !$past(step) && !$past(load)) |-> (acc_addr != $past(acc_addr)))
      else $error("advance kept address");
   input_reg_a: assert property (@(posedge clock) disable iff (rst)
      ##1 (we_n_r == $past(write_en_n) && addr_r == $past(addr_in)))
      else $error("inputs not registered");
   oe_drive_a: assert property (@(posedge clock) disable iff (rst)
      (data_oe) |-> (!out_en_n && $past(do_rd)))
      else $error("pins driven outside read");
   burst_wrap_a: assert property (@(posedge clock) disable iff (rst)
      (load ##1 step [*4]) |-> (acc_addr == $past(acc_addr, 4)))
      else $error("burst did not wrap");
endmodule

// ===== testbench/sbs_wire_model.sv
// Bus side model of the shared data pins seen by the master
`timescale 1ns/1ns
module sbs_wire_model
   import sbs_pkg::*;
(
   input  wire logic      clock,
   input  wire sbs_data_t data_out,
   input  wire logic      data_oe,
   input  wire sbs_data_t mst_data,
   input  wire logic      mst_oe,
   output sbs_data_t      data_in
);
   sbs_data_t last_r = 9'h1a5;

   // No pull on the pins: a floating bus shows a changing pattern, not a stale value
   assign data_in = (data_oe && mst_oe) ? 'x : data_oe ? data_out : mst_oe ? mst_data : ~last_r;

   // Remember the pin level so the float pattern toggles each cycle
   always_ff @(posedge clock)
      last_r <= data_in;
endmodule

// ===== testbench/sbs_top_test.sv
// Self-checking bench for the burst SRAM access block
`timescale 1ns/1ns
module sbs_top_test import sbs_pkg::*;;
   logic      clock;
   logic      rst;
   sbs_addr_t addr_in;
   logic      proc_addr_strobe_n;
   logic      ctrl_addr_strobe_n;
   logic      burst_advance_n;
   logic      write_en_n;
   logic      out_en_n;
   logic      chip_sel_high;
   logic      chip_sel_low_n;
   sbs_data_t data_in;
   sbs_data_t data_out;
   logic      data_oe;
   sbs_data_t mst_data;
   logic      mst_oe;
   int        num_errors;
   int        checked;

   // Block under test and the pin model beside it
   sbs_top i_dut (.clock, .rst, .addr_in, .proc_addr_strobe_n, .ctrl_addr_strobe_n, .burst_advance_n,
      .write_en_n, .out_en_n, .chip_sel_high, .chip_sel_low_n, .data_in, .data_out, .data_oe);
   sbs_wire_model i_wire (.clock, .data_out, .data_oe, .mst_data, .mst_oe, .data_in);

   // Free running 100 MHz clock
   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // One bus cycle; write data is driven only while write enable is low
   task automatic cyc(input logic p, c, a, w, o, input sbs_addr_t ad, input sbs_data_t d);
      proc_addr_strobe_n = p;
      ctrl_addr_strobe_n = c;
      burst_advance_n = a;
      write_en_n = w;
      out_en_n = o;
      addr_in = ad;
      mst_data = d;
      mst_oe = !w;
      @(posedge clock);
      #1;
   endtask

   // Compare pin drive and, when driven, the data
   task automatic chk(input sbs_data_t e, input logic oe);
      checked++;
      if (data_oe !== oe || (oe && data_out !== e))
      begin
         num_errors++;
         $display("mismatch %0t data %h oe %b", $time, data_out, data_oe);
      end
   endtask

   task automatic print_verdict;
      if (num_errors == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Write burst with a suspend, then a read burst that wraps and waits
   task automatic burst_test;
      sbs_data_t exp[8] = '{9'h100, 9'h101, 9'h102, 9'h0ff, 9'h100, 9'h100, 9'h100, 9'h100};
      cyc(1, 0, 1, 0, 1, 15'h1235, 9'h100);
      for (int i = 1; i < 4; i++)
         cyc(1, 1, 0, 0, 1, 15'h0000, 9'h100 | i[8:0]);
      cyc(1, 1, 1, 0, 1, 15'h0000, 9'h0ff);
      for (int i = 0; i < 9; i++)
      begin
         if (i == 0)
            cyc(0, 0, 1, 0, 0, 15'h1235, 9'h000);
         else
            cyc(1, 1, (i < 5) ? 1'b0 : 1'b1, 1, 0, 15'h0000, 9'h000);
         // Read captured one edge ago stands on the pins now
         if (i >= 1)
            chk(exp[i-1], 1'b1);
      end
   endtask

   // Controller read, output enable, selects ignored mid-burst, deselect
   task automatic select_test;
      chip_sel_high = 1'b1;
      cyc(1, 0, 1, 1, 1, 15'h1235, 9'h000);
      cyc(1, 1, 1, 1, 1, 15'h0000, 9'h000);
      chk(9'h100, 1'b0);
      out_en_n = 1'b0;
      #1;
      chk(9'h100, 1'b1);
      chip_sel_high = 1'b0;
      cyc(1, 1, 0, 1, 0, 15'h0000, 9'h000);
      cyc(1, 1, 1, 1, 0, 15'h0000, 9'h000);
      chk(9'h101, 1'b1);
      cyc(0, 1, 1, 1, 0, 15'h1235, 9'h000);
      cyc(1, 1, 0, 1, 0, 15'h0000, 9'h000);
      cyc(1, 1, 1, 1, 0, 15'h0000, 9'h000);
      cyc(1, 1, 1, 1, 0, 15'h0000, 9'h000);
      chk(9'h000, 1'b0);
   endtask

   // Write with output enable held low must not drive the pins
   task automatic write_oe_test;
      chip_sel_high = 1'b1;
      cyc(1, 0, 1, 0, 0, 15'h0400, 9'h1aa);
      cyc(1, 1, 1, 0, 0, 15'h0000, 9'h1aa);
      chk(9'h000, 1'b0);
      cyc(0, 1, 1, 1, 0, 15'h0400, 9'h000);
      cyc(1, 1, 1, 1, 0, 15'h0000, 9'h000);
      cyc(1, 1, 1, 1, 0, 15'h0000, 9'h000);
      chk(9'h1aa, 1'b1);
   endtask

   // Reset, then the scenarios; writes keep output enable high first
   initial
   begin
      num_errors = 0;
      checked = 0;
      rst = 1'b1;
      chip_sel_high = 1'b1;
      chip_sel_low_n = 1'b0;
      cyc(1, 1, 1, 1, 1, 15'h0000, 9'h000);
      repeat (15) @(posedge clock);
      #1;
      rst = 1'b0;
      burst_test();
      select_test();
      write_oe_test();
      print_verdict();
   end

   // Watchdog so a stuck run still reports
   initial
   begin
      #200000;
      num_errors++;
      print_verdict();
   end
endmodule
